// *** src/aft_buf.sv ***
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module aft_buf #(
  parameter int W = 33,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  import aft_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
      $error("DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] ent_q [DEPTH];
  logic [PW:0] wp_q;
  logic [PW:0] rp_q;

  wire [PW:0] fill = wp_q - rp_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = fill != (PW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = ent_q[rp_q[PW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (PW+1)'(push);
      rp_q <= rp_q + (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      ent_q[wp_q[PW-1:0]] <= in_data;
    end
  end

endmodule

// *** src/aft_dev.sv ***
// Board end: sample FIFO, programmed-read service and bus-master burst engine.
`timescale 1ns/1ps
module aft_dev #(
  parameter int FIFO_DEPTH = aft_pkg::FIFO_DEPTH_STD
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic smp_valid,
  input wire logic [aft_pkg::SMP_W-1:0] smp_data,
  output logic smp_drop,
  aft_link_if.dev lk
);
  import aft_pkg::*;

  // ****************************************************************
  // Derived sizes
  // ****************************************************************
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int HALF = FIFO_DEPTH / 2;
  localparam int PIO_BLK = (HALF < PIO_BLK_CAP) ? HALF : PIO_BLK_CAP;
  localparam int BM_HALF = (HALF < BM_HALF_CAP) ? HALF : BM_HALF_CAP;
  localparam int BM_PAGE = (FIFO_DEPTH <= BM_PAGE_SPLIT) ? BM_PAGE_SMALL : BM_PAGE_LARGE;

  generate
    if (FIFO_DEPTH < FIFO_DEPTH_MIN || FIFO_DEPTH > FIFO_DEPTH_MAX || (1 << AW) != FIFO_DEPTH) begin : g_bad
      $error("FIFO_DEPTH must be a power of two from 128 to 65536");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PIO = 2'h1,
    ST_BURST = 2'h2,
    ST_CHECK = 2'h3
  } aft_dev_state_t;

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [SMP_W-1:0] mem [FIFO_DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic [AW:0] rp_d;
  logic [AW:0] base_q;
  aft_dev_state_t st_q;
  aft_dev_state_t st_d;
  logic [BLK_W-1:0] left_q;
  logic [BLK_W-1:0] left_d;
  logic [BLK_W-1:0] page_q;
  logic [BLK_W-1:0] page_d;
  logic [BLK_W-1:0] blk_q;
  logic [BLK_W-1:0] blk_d;
  logic [BEAT_W-1:0] iss_q;
  logic [BEAT_W-1:0] iss_d;
  logic irq_q;
  logic ovr_q;
  logic drop_q;
  logic avail_q;
  logic rdv_q;
  logic [SMP_W-1:0] rdd_q;
  logic bmv_q;
  logic first_q;
  logic [WORD_W-1:0] bmd_q;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire [AW:0] occ_raw = wp_q - rp_q;
  wire [BLK_W-1:0] occ = BLK_W'(occ_raw);
  wire [AW:0] keep_p = ((st_q == ST_BURST) | (st_q == ST_CHECK)) ? base_q : rp_q;
  wire [AW:0] held_raw = wp_q - keep_p;
  wire is_full = held_raw == (AW+1)'(FIFO_DEPTH);
  wire wr_en = smp_valid & ~is_full;
  wire wr_lost = smp_valid & is_full;
  wire mode_short = lk.transfer_mode_setting == MODE_BM_SHORT;
  wire mode_bm = (lk.transfer_mode_setting == MODE_BM_STD) | mode_short;
  wire [BEAT_W-1:0] beats = mode_short ? BEAT_W'(BEATS_SHORT) : BEAT_W'(BEATS_STD);
  wire [BLK_W-1:0] burst_smp = BLK_W'({beats, 1'h0});
  wire [BLK_W-1:0] half_full_block_setting = BLK_W'(BM_HALF);
  wire [BLK_W-1:0] interrupt_page_setting = BLK_W'(BM_PAGE);
  wire pio_hit = ~mode_bm & (occ >= BLK_W'(PIO_BLK));
  wire fetch_hit = ~mode_bm & lk.immediate_fetch_request & (occ != '0);
  wire bm_hit = mode_bm & (occ >= half_full_block_setting);
  wire rd_has = occ_raw != '0;
  wire rd_take = (st_q == ST_PIO) & lk.rd_req;
  wire beat_load = (st_q == ST_BURST) & (iss_q != beats) & (~bmv_q | lk.bm_ready) & ~lk.bm_abort;
  wire beat_take = bmv_q & lk.bm_ready;
  wire burst_sent = (st_q == ST_BURST) & (iss_q == beats) & ~bmv_q;
  wire burst_ok = (st_q == ST_CHECK) & lk.bm_ok & ~lk.bm_abort;
  wire page_done = (page_q + burst_smp) >= interrupt_page_setting;
  wire pio_start = (st_q == ST_IDLE) & (st_d == ST_PIO);
  wire irq_set = pio_start | (burst_ok & page_done);
  wire [AW-1:0] rp_lo = rp_q[AW-1:0];
  wire [AW-1:0] rp_hi = rp_lo + AW'(1);

  // ****************************************************************
  // Transfer sequencing
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    rp_d = rp_q;
    left_d = left_q;
    page_d = page_q;
    blk_d = blk_q;
    iss_d = iss_q;
    unique case (st_q)
      ST_IDLE: begin
        if (bm_hit) begin
          st_d = ST_BURST;
          left_d = half_full_block_setting;
          iss_d = '0;
        end else if (fetch_hit) begin
          st_d = ST_PIO;
          left_d = occ;
          blk_d = occ;
        end else if (pio_hit) begin
          st_d = ST_PIO;
          left_d = BLK_W'(PIO_BLK);
          blk_d = BLK_W'(PIO_BLK);
        end
      end
      ST_PIO: begin
        if (lk.rd_req) begin
          rp_d = rp_q + (AW+1)'(rd_has);
          left_d = left_q - BLK_W'(1);
          if (left_q == BLK_W'(1)) begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_BURST: begin
        if (lk.bm_abort) begin
          rp_d = base_q;
          iss_d = '0;
        end else if (beat_load) begin
          rp_d = rp_q + (AW+1)'(2);
          iss_d = iss_q + BEAT_W'(1);
        end else if (burst_sent) begin
          st_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (lk.bm_abort) begin
          rp_d = base_q;
          iss_d = '0;
          st_d = ST_BURST;
        end else if (lk.bm_ok) begin
          left_d = left_q - burst_smp;
          page_d = page_done ? '0 : page_q + burst_smp;
          blk_d = page_done ? interrupt_page_setting : blk_q;
          iss_d = '0;
          st_d = (left_q == burst_smp) ? ST_IDLE : ST_BURST;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      rp_q <= '0;
      base_q <= '0;
      left_q <= '0;
      page_q <= '0;
      blk_q <= '0;
      iss_q <= '0;
    end else begin
      st_q <= st_d;
      rp_q <= rp_d;
      left_q <= left_d;
      page_q <= page_d;
      blk_q <= blk_d;
      iss_q <= iss_d;
      if (st_d == ST_BURST && st_q != ST_BURST) begin
        base_q <= rp_d;
      end
    end
  end

  // ****************************************************************
  // Sample intake
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(wr_en);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wp_q[AW-1:0]] <= smp_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drop_q <= 1'h0;
      ovr_q <= 1'h0;
      irq_q <= 1'h0;
      avail_q <= 1'h0;
    end else begin
      drop_q <= wr_lost;
      ovr_q <= wr_lost | (ovr_q & ~lk.ovr_clr);
      irq_q <= irq_set | (irq_q & ~lk.irq_ack);
      avail_q <= rd_has;
    end
  end

  // ****************************************************************
  // Programmed read answers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdv_q <= 1'h0;
      rdd_q <= '0;
    end else begin
      rdv_q <= rd_take;
      if (rd_take) begin
        rdd_q <= rd_has ? mem[rp_lo] : '0;
      end
    end
  end

  // ****************************************************************
  // Bus-master beats
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst || lk.bm_abort) begin
      bmv_q <= 1'h0;
      first_q <= 1'h0;
      bmd_q <= '0;
    end else if (beat_load) begin
      bmv_q <= 1'h1;
      first_q <= iss_q == '0;
      bmd_q <= {mem[rp_hi], mem[rp_lo]};
    end else if (beat_take) begin
      bmv_q <= 1'h0;
    end
  end

  assign smp_drop = drop_q;
  assign lk.irq = irq_q;
  assign lk.blk_len = blk_q;
  assign lk.fifo_avail = avail_q;
  assign lk.rd_valid = rdv_q;
  assign lk.rd_data = rdd_q;
  assign lk.bm_valid = bmv_q;
  assign lk.bm_first = first_q;
  assign lk.bm_data = bmd_q;
  assign lk.ovr_err = ovr_q;

endmodule

// *** src/aft_host.sv ***
// Host end: mode choice, programmed reads, burst intake and frame events.
`timescale 1ns/1ps
module aft_host #(
  parameter int FRAME_LEN = aft_pkg::FRAME_MIN,
  parameter int SCAN_LEN = 32'h0000_0001,
  parameter int DEST_LEN = aft_pkg::DEST_INIT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire aft_pkg::aft_mode_t mode,
  input wire logic fetch_now,
  input wire logic ovr_clear,
  output logic mem_valid,
  output logic mem_pair,
  output logic [aft_pkg::ADDR_W-1:0] mem_addr,
  output logic [aft_pkg::WORD_W-1:0] mem_data,
  input wire logic mem_ready,
  input wire logic mem_abort,
  output logic frame_evt,
  output logic ovr_seen,
  aft_link_if.host lk
);
  import aft_pkg::*;

  // ****************************************************************
  // Checks and types
  // ****************************************************************
  generate
    if (DEST_LEN < DEST_INIT || DEST_LEN > DEST_MAX || FRAME_LEN < 2 || (FRAME_LEN % 2) != 0 ||
        (DEST_LEN % FRAME_LEN) != 0 || SCAN_LEN < 1 || (FRAME_LEN % SCAN_LEN) != 0) begin : g_bad
      $error("DEST_LEN, FRAME_LEN or SCAN_LEN out of range");
    end
  endgenerate

  localparam logic BM_ALLOWED = FRAME_LEN >= FRAME_MIN;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_CHK = 2'h1,
    H_WAIT = 2'h2,
    H_GAP = 2'h3
  } aft_host_state_t;

  aft_host_state_t st_q;
  aft_mode_t mode_q;
  logic [BLK_W-1:0] left_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] base_q;
  logic [BEAT_W-1:0] ob_q;
  logic ack_q, rdq_q, fetch_q, clr_q, ok_q, abort_q, drop_q, frame_q, ovr_q;
  logic buf_rdy, buf_ov, buf_pair;
  logic [WORD_W-1:0] buf_data;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire want_bm = (mode == MODE_BM_STD) | (mode == MODE_BM_SHORT);
  wire in_bm = (mode_q == MODE_BM_STD) | (mode_q == MODE_BM_SHORT);
  wire [BEAT_W-1:0] beats = (mode_q == MODE_BM_SHORT) ? BEAT_W'(BEATS_SHORT) : BEAT_W'(BEATS_STD);
  wire irq_new = lk.irq & ~ack_q;
  wire irq_take = irq_new & (in_bm | (st_q == H_IDLE));
  wire go_rd = buf_rdy & ((mode_q == MODE_FAST) | lk.fifo_avail);
  wire pio_push = (st_q == H_WAIT) & lk.rd_valid;
  wire bm_push = lk.bm_valid & buf_rdy & (~drop_q | lk.bm_first) & in_bm;
  wire taken = buf_ov & mem_ready & ~mem_abort;
  wire aborted = buf_ov & mem_abort & buf_pair;
  wire [ADDR_W:0] sum = {1'h0, addr_q} + (buf_pair ? (ADDR_W+1)'(2) : (ADDR_W+1)'(1));
  wire [ADDR_W:0] wrapped = (sum >= (ADDR_W+1)'(DEST_LEN)) ? sum - (ADDR_W+1)'(DEST_LEN) : sum;
  wire [ADDR_W-1:0] addr_n = wrapped[ADDR_W-1:0];
  wire crossed = ((int'(addr_q) / FRAME_LEN) != (int'(addr_n) / FRAME_LEN)) |
                 (sum >= (ADDR_W+1)'(DEST_LEN));
  wire burst_end = buf_pair & (ob_q + BEAT_W'(1) == beats);
  wire [WORD_W:0] push_word = pio_push ? {1'h0, {(WORD_W-SMP_W){1'h0}}, lk.rd_data} : {1'h1, lk.bm_data};

  aft_buf #(
    .W(WORD_W + 1),
    .DEPTH(2)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(aborted),
    .in_valid(pio_push | bm_push),
    .in_data(push_word),
    .in_ready(buf_rdy),
    .out_valid(buf_ov),
    .out_data({buf_pair, buf_data}),
    .out_ready(mem_ready & ~mem_abort)
  );

  // ****************************************************************
  // Programmed reads
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= H_IDLE;
      left_q <= '0;
      rdq_q <= 1'h0;
    end else begin
      rdq_q <= 1'h0;
      unique case (st_q)
        H_IDLE: if (irq_new && !in_bm) begin
          left_q <= lk.blk_len;
          st_q <= H_CHK;
        end
        H_CHK: if (left_q == '0) begin
          st_q <= H_IDLE;
        end else if (go_rd) begin
          rdq_q <= 1'h1;
          st_q <= H_WAIT;
        end
        H_WAIT: if (lk.rd_valid) begin
          left_q <= left_q - BLK_W'(1);
          st_q <= H_GAP;
        end
        H_GAP: st_q <= H_CHK;
      endcase
    end
  end

  // ****************************************************************
  // Settings and simple pulses
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= MODE_FAST;
      ack_q <= 1'h0;
      fetch_q <= 1'h0;
      clr_q <= 1'h0;
      ovr_q <= 1'h0;
    end else begin
      mode_q <= (want_bm && !BM_ALLOWED) ? MODE_FAST : mode;
      ack_q <= irq_take;
      fetch_q <= fetch_now & ~want_bm;
      clr_q <= ovr_clear;
      ovr_q <= lk.ovr_err;
    end
  end

  // ****************************************************************
  // Destination writes and burst bookkeeping
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_q <= '0;
      base_q <= '0;
      ob_q <= '0;
      ok_q <= 1'h0;
      abort_q <= 1'h0;
      drop_q <= 1'h0;
      frame_q <= 1'h0;
    end else begin
      ok_q <= taken & burst_end;
      abort_q <= aborted;
      frame_q <= taken & crossed;
      if (aborted) begin
        addr_q <= base_q;
        ob_q <= '0;
        drop_q <= 1'h1;
      end else begin
        if (lk.bm_valid && lk.bm_first && buf_rdy) begin
          drop_q <= 1'h0;
        end
        if (taken) begin
          addr_q <= addr_n;
          ob_q <= (burst_end || !buf_pair) ? '0 : ob_q + BEAT_W'(1);
          if (burst_end || !buf_pair) begin
            base_q <= addr_n;
          end
        end
      end
    end
  end

  assign lk.transfer_mode_setting = mode_q;
  assign lk.immediate_fetch_request = fetch_q;
  assign lk.irq_ack = ack_q;
  assign lk.rd_req = rdq_q;
  assign lk.bm_ready = buf_rdy;
  assign lk.bm_ok = ok_q;
  assign lk.bm_abort = abort_q;
  assign lk.ovr_clr = clr_q;
  assign mem_valid = buf_ov;
  assign mem_pair = buf_pair;
  assign mem_data = buf_data;
  assign mem_addr = addr_q;
  assign frame_evt = frame_q;
  assign ovr_seen = ovr_q;

endmodule

// *** src/aft_link_if.sv ***
// Link between the acquisition board end and the host end.
`timescale 1ns/1ps
interface aft_link_if;
  import aft_pkg::*;

  aft_mode_t transfer_mode_setting;
  logic immediate_fetch_request;
  logic irq;
  logic irq_ack;
  logic [BLK_W-1:0] blk_len;
  logic fifo_avail;
  logic rd_req;
  logic rd_valid;
  logic [SMP_W-1:0] rd_data;
  logic bm_valid;
  logic bm_first;
  logic [WORD_W-1:0] bm_data;
  logic bm_ready;
  logic bm_ok;
  logic bm_abort;
  logic ovr_err;
  logic ovr_clr;

  modport dev (
    input transfer_mode_setting, immediate_fetch_request, irq_ack, rd_req, bm_ready, bm_ok, bm_abort, ovr_clr,
    output irq, blk_len, fifo_avail, rd_valid, rd_data, bm_valid, bm_first, bm_data, ovr_err
  );

  modport host (
    output transfer_mode_setting, immediate_fetch_request, irq_ack, rd_req, bm_ready, bm_ok, bm_abort, ovr_clr,
    input irq, blk_len, fifo_avail, rd_valid, rd_data, bm_valid, bm_first, bm_data, ovr_err
  );

endinterface

// *** src/aft_pkg.sv ***
// Shared constants and types for the sample FIFO to host transfer block.
package aft_pkg;

  // ****************************************************************
  // Sizes and limits
  // ****************************************************************
  localparam int FIFO_DEPTH_STD = 32'h0000_0400;
  localparam int FIFO_DEPTH_MIN = 32'h0000_0080;
  localparam int FIFO_DEPTH_MAX = 32'h0001_0000;
  localparam int PIO_BLK_CAP = 32'h0000_1000;
  localparam int BM_HALF_CAP = 32'h0000_2000;
  localparam int BM_PAGE_SMALL = 32'h0000_1000;
  localparam int BM_PAGE_LARGE = 32'h0000_2000;
  localparam int BM_PAGE_SPLIT = 32'h0000_2000;
  localparam int BEATS_STD = 32'h0000_0020;
  localparam int BEATS_SHORT = 32'h0000_0008;
  localparam int DEST_INIT = 32'h0000_1000;
  localparam int DEST_MAX = 32'h0000_4000;
  localparam int FRAME_MIN = 32'h0000_1000;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int SMP_W = 32'h0000_0010;
  localparam int WORD_W = 32'h0000_0020;
  localparam int BLK_W = 32'h0000_0011;
  localparam int ADDR_W = 32'h0000_000F;
  localparam int BEAT_W = 32'h0000_0006;

  // ****************************************************************
  // Transfer modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_FAST = 2'h1,
    MODE_BM_STD = 2'h2,
    MODE_BM_SHORT = 2'h3
  } aft_mode_t;

endpackage

// *** test/aft_chk.sv ***
// Link checker for the board end and host end.
`timescale 1ns/1ps
module aft_chk #(
  parameter int FIFO_DEPTH = aft_pkg::FIFO_DEPTH_STD
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire aft_pkg::aft_mode_t transfer_mode_setting,
  input wire logic irq,
  input wire logic irq_ack,
  input wire logic [aft_pkg::BLK_W-1:0] blk_len,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic fifo_avail,
  input wire logic bm_valid,
  input wire logic bm_first,
  input wire logic bm_ready,
  input wire logic bm_ok,
  input wire logic bm_abort,
  input wire logic ovr_err,
  input wire logic ovr_clr
);
  import aft_pkg::*;
  // *****
  // Beat counter and checks.
  // *****
  localparam int HALF = (FIFO_DEPTH / 2 < PIO_BLK_CAP) ? FIFO_DEPTH / 2 : PIO_BLK_CAP;
  localparam int PAGE = (FIFO_DEPTH <= BM_PAGE_SPLIT) ? BM_PAGE_SMALL : BM_PAGE_LARGE;
  logic [6:0] beat_q;
  logic [6:0] beat_d;
  logic taken;
  logic pio;
  assign taken = bm_valid && bm_ready;
  assign pio = transfer_mode_setting inside {MODE_NORMAL, MODE_FAST};
  assign beat_d = !taken ? beat_q : (bm_first ? 7'h01 : beat_q + 7'h01);
  always_ff @(posedge clk_sys) begin
    beat_q <= rst ? 7'h00 : beat_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd_req |=> rd_valid) else $error("read not answered");
  a_read_cause: assert property (rd_valid |-> $past(rd_req)) else $error("read answer unasked");
  a_checked_read: assert property (rd_req && transfer_mode_setting == MODE_NORMAL |-> fifo_avail)
    else $error("unchecked read in normal mode");
  a_pio_block: assert property ($rose(irq) && pio |-> blk_len != 0 && blk_len <= HALF)
    else $error("bad read block size");
  a_bm_page: assert property ($rose(irq) && !pio |-> blk_len == PAGE) else $error("bad page size");
  a_irq_held: assert property (irq && !irq_ack |=> irq) else $error("interrupt dropped");
  a_burst_len: assert property (bm_ok |->
    beat_q == (transfer_mode_setting == MODE_BM_STD ? BEATS_STD : BEATS_SHORT))
    else $error("bad burst length");
  a_abort_resend: assert property (bm_abort |=> ##[0:16] (bm_valid && bm_first))
    else $error("burst not resent");
  a_ovr_sticky: assert property (ovr_err && !ovr_clr |=> ovr_err) else $error("overrun flag lost");
  c_page: cover property ($rose(irq) && !pio);
  c_abort: cover property (bm_abort);
  c_ovr: cover property ($rose(ovr_err));
  c_normal: cover property (rd_valid && transfer_mode_setting == MODE_NORMAL);
endmodule

// *** test/tb_adc_fifo_host_transfer.sv ***
// Bench joining the board end and the host end.
`timescale 1ns/1ps
module tb_adc_fifo_host_transfer;
  import aft_pkg::*;
  localparam int DEPTH = 32'h0000_0080;
  localparam int HALF = DEPTH / 2;
  localparam int LIMIT = 32'h0000_4E20;
  logic clk_sys, rst, smp_valid, smp_drop, fetch_now, ovr_clear, mem_valid, mem_pair;
  logic mem_ready, mem_abort, frame_evt, ovr_seen;
  logic [SMP_W-1:0] smp_data;
  aft_mode_t mode;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_data;
  int fail_count, check_count, cyc, drops, frames;
  logic [WORD_W-1:0] got_d[$];
  logic [ADDR_W-1:0] got_a[$];
  logic got_p[$];
  aft_link_if lk();
  aft_dev #(.FIFO_DEPTH(DEPTH)) i_aft_dev (.clk_sys(clk_sys), .rst(rst), .smp_valid(smp_valid),
    .smp_data(smp_data), .smp_drop(smp_drop), .lk(lk));
  aft_host i_aft_host (.clk_sys(clk_sys), .rst(rst), .mode(mode), .fetch_now(fetch_now), .ovr_clear(ovr_clear),
    .mem_valid(mem_valid), .mem_pair(mem_pair), .mem_addr(mem_addr), .mem_data(mem_data), .mem_ready(mem_ready),
    .mem_abort(mem_abort), .frame_evt(frame_evt), .ovr_seen(ovr_seen), .lk(lk));
  aft_chk #(.FIFO_DEPTH(DEPTH)) i_aft_chk (.clk_sys(clk_sys), .rst(rst),
    .transfer_mode_setting(lk.transfer_mode_setting), .irq(lk.irq), .irq_ack(lk.irq_ack), .blk_len(lk.blk_len),
    .rd_req(lk.rd_req), .rd_valid(lk.rd_valid), .fifo_avail(lk.fifo_avail), .bm_valid(lk.bm_valid),
    .bm_first(lk.bm_first), .bm_ready(lk.bm_ready), .bm_ok(lk.bm_ok), .bm_abort(lk.bm_abort),
    .ovr_err(lk.ovr_err), .ovr_clr(lk.ovr_clr));
  // *****
  // Clock, monitor and helpers.
  // *****
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      got_d.push_back(mem_data);
      got_a.push_back(mem_addr);
      got_p.push_back(mem_pair);
    end
    if (smp_drop === 1'b1) drops++;
    if (frame_evt === 1'b1) frames++;
    if (cyc == LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input aft_mode_t m);
    @(negedge clk_sys);
    mode = m;
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    got_d.delete();
    got_a.delete();
    got_p.delete();
    drops = 0;
    frames = 0;
    mem_ready = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic push(input int base, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      smp_valid = 1'b1;
      smp_data = SMP_W'(base + i);
    end
    @(negedge clk_sys);
    smp_valid = 1'b0;
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 20000 && got_d.size() < n; k++) @(negedge clk_sys);
    check(got_d.size() >= n, "words missing");
  endtask
  task automatic check_pio(input int base, input int n);
    for (int i = 0; i < n; i++) begin
      check(got_d[i][SMP_W-1:0] === SMP_W'(base + i) && got_p[i] === 1'b0 && got_a[i] === ADDR_W'(i), "read word");
    end
  endtask
  // *****
  // Scenarios.
  // *****
  task automatic t_pio(input aft_mode_t m);
    do_reset(m);
    push(32'h0000_1000, 30);
    repeat (40) @(negedge clk_sys);
    check(got_d.size() == 0, "block before half full");
    push(32'h0000_101E, HALF - 30);
    wait_words(HALF);
    check_pio(32'h0000_1000, HALF);
  endtask
  task automatic t_fetch();
    do_reset(MODE_FAST);
    push(32'h0000_2000, 10);
    repeat (20) @(negedge clk_sys);
    fetch_now = 1'b1;
    @(negedge clk_sys);
    fetch_now = 1'b0;
    wait_words(10);
    check_pio(32'h0000_2000, 10);
  endtask
  task automatic t_ovr();
    do_reset(MODE_FAST);
    mem_ready = 1'b0;
    push(32'h0000_3000, DEPTH + 16);
    repeat (4) @(negedge clk_sys);
    check(drops > 0 && drops <= 16 && ovr_seen === 1'b1, "overrun");
    mem_ready = 1'b1;
    wait_words(HALF);
    check_pio(32'h0000_3000, HALF);
    ovr_clear = 1'b1;
    @(negedge clk_sys);
    ovr_clear = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(ovr_seen === 1'b0, "overrun clear");
    wait_words(2 * HALF);
    check_pio(32'h0000_3000, 2 * HALF);
  endtask
  task automatic t_bm_std();
    do_reset(MODE_BM_STD);
    push(0, 32'h0000_1000);
    wait_words(32'h0000_0800);
    for (int i = 0; i < 32'h0000_0800; i++) begin
      check(got_d[i] === {SMP_W'(2 * i + 1), SMP_W'(2 * i)} && got_p[i] === 1'b1 &&
            got_a[i] === ADDR_W'(2 * i), "bm word");
    end
    repeat (8) @(negedge clk_sys);
    check(frames == 1 && drops == 0, "frame count or drop");
    check(lk.blk_len === BLK_W'(BM_PAGE_SMALL), "no page interrupt");
    check(lk.transfer_mode_setting === MODE_BM_STD, "bus-master mode refused");
  endtask
  task automatic t_bm_short();
    logic [WORD_W-1:0] img [32];
    do_reset(MODE_BM_SHORT);
    push(32'h0000_4000, HALF);
    wait_words(2);
    mem_ready = 1'b0;
    for (int k = 0; k < 100 && mem_valid !== 1'b1; k++) @(negedge clk_sys);
    mem_abort = 1'b1;
    @(negedge clk_sys);
    mem_abort = 1'b0;
    mem_ready = 1'b1;
    wait_words(34);
    repeat (50) @(negedge clk_sys);
    check(got_d.size() == 34, "burst not resent whole");
    foreach (got_d[j]) img[got_a[j][5:1]] = got_d[j];
    for (int j = 0; j < 32; j++) begin
      check(img[j] === {SMP_W'(32'h0000_4001 + 2 * j), SMP_W'(32'h0000_4000 + 2 * j)}, "short bm word");
    end
  endtask
  initial begin
    rst = 1'b1;
    smp_valid = 1'b0;
    smp_data = 16'h0000;
    mode = MODE_FAST;
    fetch_now = 1'b0;
    ovr_clear = 1'b0;
    mem_ready = 1'b1;
    mem_abort = 1'b0;
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    t_pio(MODE_NORMAL);
    t_pio(MODE_FAST);
    t_fetch();
    t_ovr();
    t_bm_std();
    t_bm_short();
    tally_and_finish();
  end
endmodule
